// ---- hdl/spc_params.svh ----
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
// ****************************************
// register byte addresses
// ****************************************
`define SPC_ADDR_STA     32'hffff0a00
`define SPC_ADDR_RX      32'hffff0a04
`define SPC_ADDR_TX      32'hffff0a08
`define SPC_ADDR_DIV     32'hffff0a0c
`define SPC_ADDR_CON     32'hffff0a10
// ****************************************
// port_control field positions
// ****************************************
`define SPC_CON_CONT     12
`define SPC_CON_LOOP     11
`define SPC_CON_OD       10
`define SPC_CON_CSDIS    9
`define SPC_CON_OVWR     8
`define SPC_CON_UNDZ     7
`define SPC_CON_TXMODE   6
`define SPC_CON_LSB      5
`define SPC_CON_CPOL     3
`define SPC_CON_CPHA     2
`define SPC_CON_MSTR     1
`define SPC_CON_EN       0
`define SPC_CON_MASK     16'h1fef
// ****************************************
// reset values
// ****************************************
`define SPC_DIV_RST      8'h1b
`define SPC_CON_RST      16'h0000
`define SPC_TX_RST       8'h00
// ****************************************
// timing counts
// ****************************************
`define SPC_LAST_HALF    5'h0f
`define SPC_LAST_BIT     5'h07
`define SPC_STALL_HALVES 2
`endif

// ---- hdl/spc_pkg.sv ----
package spc_pkg;
  // master sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_xfer,
    st_stall
  } spc_state_t;
endpackage

// ---- hdl/spc_rate_if.sv ----
`timescale 1ns/1ps
// divider setting, run request and half-period tick
interface spc_rate_if #(
  parameter int DIV_W = 8
);
  logic [DIV_W-1:0] div;  // divider value
  logic             run;  // count while high
  logic             tick; // one-cycle half-period pulse
  modport engine (output div, output run, input tick);
  modport gen    (input div, input run, output tick);
endinterface

// ---- hdl/spc_rate_gen.sv ----
`timescale 1ns/1ps
module spc_rate_gen #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic  pclk,
  input wire logic  presetn,
  // rate carrier
  spc_rate_if.gen   rate
);
  // ****************************************
  // half-period counter
  // ****************************************
  logic [DIV_W-1:0] cnt_q; // cycles into the half period
  logic [DIV_W-1:0] cnt_d;

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("spc_rate_gen: DIV_W out of range");
  end

  // one tick every div+1 cycles, so a full period is 2*(div+1)
  always_comb begin
    cnt_d     = '0;
    rate.tick = 1'b0;
    if (rate.run) begin
      if (cnt_q == rate.div) begin
        rate.tick = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // restart from zero whenever idle so each frame starts aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ---- hdl/spc_port.sv ----
`timescale 1ns/1ps
`include "spc_params.svh"
// ****************************************
// serial port control and transmit side
// ****************************************
// Summary of operation
// - write-only byte transmit holding register
// - byte divider register, resets to 1b
// - 16-bit control, bits 15:13, 4 reserved
// - continuous mode streams bytes, select held low
// - single mode: one byte, stall before next
// - loopback feeds data out into data in
// - open-drain slave data out option
// - master chip-select output can be disabled
// - overflow: overwrite or discard new byte
// - underflow: send zero or previous byte
// - transmit mode: write starts, empty flags
// - receive mode: read starts, full flags
// - bit order selectable lsb or msb
// - clock idle level set by polarity
// - clock phase: pulse at start or end
// - master or slave role select
// - port enable; control resets to zero
// - rate is clock over 2*(1+divider)
// - overflow status on overwrite or discard
// - slave frames bounded by low select
// - eight clock periods, opposite edges
module spc_port #(
  parameter int STALL_HALVES = `SPC_STALL_HALVES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial clock pin
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  // master-out data pin
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  // master-in data pin
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  // chip select pin, active low
  input  wire logic        cs_n_i,
  output logic             cs_n_o,
  output logic             cs_n_oe
);
  if (STALL_HALVES < 1 || STALL_HALVES > 16) begin : g_chk
    $error("spc_port: STALL_HALVES out of range");
  end

  // ****************************************
  // helpers
  // ****************************************
  // bit presented on the data line
  function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
    out_bit = lsb ? sh[0] : sh[7];
  endfunction

  // move the transmit shifter on by one bit
  function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic lsb);
    shift_out = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
  endfunction

  // take one received bit into the receive shifter
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  spc_rate_if #(.DIV_W(8)) rate ();   // carrier to the divider

  logic [15:0]             con_q;     // port_control
  logic [15:0]             con_d;
  logic [7:0]              div_q;     // serial_clock_divider
  logic [7:0]              div_d;
  logic [7:0]              tx_hold_q; // transmit_holding
  logic [7:0]              tx_hold_d;
  logic                    txv_q;     // transmit data valid
  logic                    txv_d;
  logic                    und_q;     // transmit underflow
  logic                    und_d;
  logic [7:0]              rx_q;      // receive_holding
  logic [7:0]              rx_d;
  logic                    rxf_q;     // receive full
  logic                    rxf_d;
  logic                    ovf_q;     // receive overflow
  logic                    ovf_d;
  logic [7:0]              last_q;    // byte sent last, for underflow resend
  logic [7:0]              last_d;
  spc_pkg::spc_state_t     state_q;   // master sequencer
  spc_pkg::spc_state_t     state_d;
  logic [4:0]              cnt_q;     // master half periods or slave bits
  logic [4:0]              cnt_d;
  logic [7:0]              tx_sh_q;   // transmit shifter
  logic [7:0]              tx_sh_d;
  logic [7:0]              rx_sh_q;   // receive shifter
  logic [7:0]              rx_sh_d;
  logic                    skip_q;    // suppress next slave shift edge
  logic                    skip_d;
  logic                    sclk_p_q;  // previous slave clock sample
  logic                    cs_p_q;    // previous slave select sample
  logic                    rd_req_q;  // receive-read start request
  logic                    rd_req_d;
  logic [31:0]             prdata_d;
  logic                    pready_d;
  logic                    pslverr_d;
  logic                    sclk_d;
  logic                    mosi_d;
  logic                    miso_d;
  logic                    miso_oe_d;
  logic                    cs_n_d;
  logic                    moe_d;     // master drives clock and data out
  logic                    cs_oe_d;
  logic                    setup;     // apb setup phase
  logic                    acc;       // apb access completes this edge
  logic                    hit;       // address maps to a register
  logic                    rd_ev;     // receive register read completes
  logic                    load_ev;   // start of a byte, fill shifter
  logic                    done_ev;   // byte complete
  logic                    en;
  logic                    master;
  logic                    lsb;
  logic                    cpha;
  logic                    rx_bit;    // data bit to sample
  logic                    lead;      // slave clock leaves idle level
  logic                    trail;     // slave clock returns to idle level
  logic [5:0]              sta;       // port_status view

  // ****************************************
  // control decode
  // ****************************************
  assign en     = con_q[`SPC_CON_EN];
  assign master = con_q[`SPC_CON_MSTR];
  assign lsb    = con_q[`SPC_CON_LSB];
  assign cpha   = con_q[`SPC_CON_CPHA];
  // loopback samples our own data out instead of the pin
  assign rx_bit = con_q[`SPC_CON_LOOP] ? out_bit(tx_sh_q, lsb) :
                  (master ? miso_i : mosi_i);
  assign lead   = (sclk_i != sclk_p_q) && (sclk_p_q == con_q[`SPC_CON_CPOL]);
  assign trail  = (sclk_i != sclk_p_q) && (sclk_p_q != con_q[`SPC_CON_CPOL]);
  // irq-style bits are plain status; no interrupt line here
  assign sta    = {ovf_q, rxf_q | ovf_q, rxf_q, und_q, en & (~txv_q | und_q), txv_q};

  // divider runs only while the master is moving
  assign rate.div = div_q;
  assign rate.run = en && master && (state_q != spc_pkg::st_idle);

  spc_rate_gen #(.DIV_W(8)) u_rate (
    .pclk    (pclk),
    .presetn (presetn),
    .rate    (rate)
  );

  // ****************************************
  // apb slave
  // ****************************************
  assign setup = psel && !penable;
  assign acc   = psel && penable && pready;
  assign hit   = (paddr == `SPC_ADDR_STA) || (paddr == `SPC_ADDR_RX) ||
                 (paddr == `SPC_ADDR_TX) || (paddr == `SPC_ADDR_DIV) ||
                 (paddr == `SPC_ADDR_CON);
  assign rd_ev = acc && !pwrite && (paddr == `SPC_ADDR_RX);

  // no wait state: answer is prepared in setup, shown in access
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup && !hit;
    prdata_d  = prdata;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `SPC_ADDR_STA: prdata_d = {26'h000_0000, sta};
          `SPC_ADDR_RX:  prdata_d = {24'h00_0000, rx_q};
          `SPC_ADDR_DIV: prdata_d = {24'h00_0000, div_q};
          `SPC_ADDR_CON: prdata_d = {16'h0000, con_q};
          // transmit holding is write-only and reads zero
          default:       prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ****************************************
  // registers and status flags
  // ****************************************
  // clears come first so a same-cycle hardware set wins
  always_comb begin
    con_d     = con_q;
    div_d     = div_q;
    tx_hold_d = tx_hold_q;
    txv_d     = txv_q;
    und_d     = und_q;
    rx_d      = rx_q;
    rxf_d     = rxf_q;
    ovf_d     = ovf_q;
    last_d    = last_q;
    if (rd_ev) begin
      rxf_d = 1'b0;
      ovf_d = 1'b0;
    end
    if (load_ev) begin
      if (txv_q) begin
        txv_d  = 1'b0;
        last_d = tx_hold_q;
      end else begin
        und_d = 1'b1;
      end
    end
    if (done_ev) begin
      if (rxf_q && !rd_ev) begin
        ovf_d = 1'b1;
        if (con_q[`SPC_CON_OVWR]) begin
          rx_d = rx_sh_d;
        end
      end else begin
        rx_d  = rx_sh_d;
        rxf_d = 1'b1;
      end
    end
    if (acc && pwrite) begin
      case (paddr)
        `SPC_ADDR_TX: begin
          tx_hold_d = pwdata[7:0];
          txv_d     = 1'b1;
          if (!(load_ev && !txv_q)) begin
            und_d = 1'b0;
          end
        end
        `SPC_ADDR_DIV: div_d = pwdata[7:0];
        `SPC_ADDR_CON: con_d = pwdata[15:0] & `SPC_CON_MASK;
        // status and receive are read-only
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_q     <= `SPC_CON_RST;
      div_q     <= `SPC_DIV_RST;
      tx_hold_q <= `SPC_TX_RST;
      txv_q     <= 1'b0;
      und_q     <= 1'b0;
      rx_q      <= 8'h00;
      rxf_q     <= 1'b0;
      ovf_q     <= 1'b0;
      last_q    <= 8'h00;
    end else begin
      con_q     <= con_d;
      div_q     <= div_d;
      tx_hold_q <= tx_hold_d;
      txv_q     <= txv_d;
      und_q     <= und_d;
      rx_q      <= rx_d;
      rxf_q     <= rxf_d;
      ovf_q     <= ovf_d;
      last_q    <= last_d;
    end
  end

  // ****************************************
  // shift engine
  // ****************************************
  // even half periods end in a sample, odd ones in a shift
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    tx_sh_d  = tx_sh_q;
    rx_sh_d  = rx_sh_q;
    skip_d   = skip_q;
    load_ev  = 1'b0;
    done_ev  = 1'b0;
    rd_req_d = rd_req_q;
    if (rd_ev && !con_q[`SPC_CON_TXMODE]) begin
      rd_req_d = 1'b1;
    end
    if (!en) begin
      // disabling aborts any byte in flight
      state_d  = spc_pkg::st_idle;
      cnt_d    = 5'h00;
      skip_d   = 1'b0;
      rd_req_d = 1'b0;
    end else if (master) begin
      case (state_q)
        spc_pkg::st_idle: begin
          if (con_q[`SPC_CON_TXMODE] ? txv_q : rd_req_q) begin
            load_ev  = 1'b1;
            state_d  = spc_pkg::st_xfer;
            cnt_d    = 5'h00;
            rd_req_d = 1'b0;
          end
        end
        spc_pkg::st_xfer: begin
          if (rate.tick) begin
            cnt_d = cnt_q + 5'h01;
            if (!cnt_q[0]) begin
              rx_sh_d = shift_in(rx_sh_q, rx_bit, lsb);
            end else if (cnt_q == `SPC_LAST_HALF) begin
              done_ev = 1'b1;
              cnt_d   = 5'h00;
              if (con_q[`SPC_CON_CONT] && txv_q) begin
                load_ev = 1'b1;
              end else begin
                state_d = spc_pkg::st_stall;
              end
            end else begin
              tx_sh_d = shift_out(tx_sh_q, lsb);
            end
          end
        end
        spc_pkg::st_stall: begin
          if (rate.tick) begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(STALL_HALVES - 1)) begin
              state_d = spc_pkg::st_idle;
              cnt_d   = 5'h00;
            end
          end
        end
        default: state_d = spc_pkg::st_idle;
      endcase
    end else begin
      state_d = spc_pkg::st_idle;
      if (cs_n_i) begin
        cnt_d = 5'h00;
      end else if (cs_p_q) begin
        // select just fell: first byte is ready before any edge
        load_ev = 1'b1;
        cnt_d   = 5'h00;
        skip_d  = cpha;
      end else if (cpha ? trail : lead) begin
        rx_sh_d = shift_in(rx_sh_q, rx_bit, lsb);
        cnt_d   = cnt_q + 5'h01;
        if (cnt_q == `SPC_LAST_BIT) begin
          done_ev = 1'b1;
          load_ev = 1'b1;
          cnt_d   = 5'h00;
          skip_d  = 1'b1;
        end
      end else if (cpha ? lead : trail) begin
        if (skip_q) begin
          skip_d = 1'b0;
        end else begin
          tx_sh_d = shift_out(tx_sh_q, lsb);
        end
      end
    end
    if (load_ev) begin
      tx_sh_d = txv_q ? tx_hold_q :
                (con_q[`SPC_CON_UNDZ] ? 8'h00 : last_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= spc_pkg::st_idle;
      cnt_q    <= 5'h00;
      tx_sh_q  <= 8'h00;
      rx_sh_q  <= 8'h00;
      skip_q   <= 1'b0;
      rd_req_q <= 1'b0;
      sclk_p_q <= 1'b0;
      cs_p_q   <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      tx_sh_q  <= tx_sh_d;
      rx_sh_q  <= rx_sh_d;
      skip_q   <= skip_d;
      rd_req_q <= rd_req_d;
      sclk_p_q <= sclk_i;
      cs_p_q   <= cs_n_i;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // all pins lag the engine by one cycle, uniformly
  always_comb begin
    moe_d   = en && master;
    sclk_d  = con_q[`SPC_CON_CPOL];
    if (moe_d && state_q == spc_pkg::st_xfer) begin
      sclk_d = con_q[`SPC_CON_CPOL] ^ (cpha ? ~cnt_q[0] : cnt_q[0]);
    end
    mosi_d    = out_bit(tx_sh_q, lsb);
    cs_n_d    = !(moe_d && state_q == spc_pkg::st_xfer);
    cs_oe_d   = moe_d && !con_q[`SPC_CON_CSDIS];
    // open drain only ever pulls low
    miso_d    = con_q[`SPC_CON_OD] ? 1'b0 : out_bit(tx_sh_q, lsb);
    miso_oe_d = en && !master && !cs_n_i &&
                (!con_q[`SPC_CON_OD] || !out_bit(tx_sh_q, lsb));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_o  <= 1'b0;
      sclk_oe <= 1'b0;
      mosi_o  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
      cs_n_o  <= 1'b1;
      cs_n_oe <= 1'b0;
    end else begin
      sclk_o  <= sclk_d;
      sclk_oe <= moe_d;
      mosi_o  <= mosi_d;
      mosi_oe <= moe_d;
      miso_o  <= miso_d;
      miso_oe <= miso_oe_d;
      cs_n_o  <= cs_n_d;
      cs_n_oe <= cs_oe_d;
    end
  end
endmodule

// ---- verification/spc_port_monitor.sv ----
`timescale 1ns/1ps
`include "spc_params.svh"
module spc_port_monitor #(
  parameter int STALL_HALVES = 2
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // serial pins
  input wire logic        sclk_o,
  input wire logic        sclk_oe,
  input wire logic        miso_o,
  input wire logic        miso_oe,
  input wire logic        cs_n_o,
  input wire logic        cs_n_oe
);
  // ****
  // shadow registers and counters
  // ****
  logic [15:0] con_q;  // control as written
  logic [7:0]  div_q;  // divider as written
  logic [8:0]  run_q;  // cycles since clock change
  logic [12:0] low_q;  // cycles with select low
  logic [12:0] hi_q;   // cycles with select high, saturating
  wire         wr_c   = psel & penable & pready & pwrite;
  wire         rd_c   = psel & penable & pready & ~pwrite;
  wire  [8:0]  half_w = {1'b0, div_q} + 9'h001;
  // counters replace long repetitions so the tools stay quick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_q <= `SPC_CON_RST;
      div_q <= `SPC_DIV_RST;
      run_q <= 9'h000;
      low_q <= 13'h0000;
      hi_q  <= 13'h0000;
    end else begin
      if (wr_c && paddr == `SPC_ADDR_CON) begin
        con_q <= pwdata[15:0] & `SPC_CON_MASK;
      end
      if (wr_c && paddr == `SPC_ADDR_DIV) begin
        div_q <= pwdata[7:0];
      end
      run_q <= (cs_n_o || $fell(cs_n_o) || $changed(sclk_o)) ? 9'h000 : run_q + 9'h001;
      low_q <= cs_n_o ? 13'h0000 : low_q + 13'h0001;
      hi_q  <= (!cs_n_o) ? 13'h0000 : ((&hi_q) ? hi_q : hi_q + 13'h0001);
    end
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pready_follows_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  tx_reads_zero_a: assert property (rd_c && paddr == `SPC_ADDR_TX |-> prdata == 32'h0)
    else $error("transmit read not zero");
  div_readback_a: assert property (rd_c && paddr == `SPC_ADDR_DIV |-> prdata[7:0] == div_q)
    else $error("divider readback wrong");
  con_reserved_a: assert property (rd_c && paddr == `SPC_ADDR_CON |-> prdata == {16'h0, con_q})
    else $error("control readback wrong");
  cs_disable_a: assert property (con_q[9] && $past(con_q[9]) |-> !cs_n_oe)
    else $error("select driven while disabled");
  open_drain_a: assert property (con_q[10] && $past(con_q[10]) |-> !(miso_oe && miso_o))
    else $error("data out driven high in open drain");
  idle_level_a: assert property (sclk_oe && cs_n_o && $past(cs_n_o) && $past(cs_n_o, 2)
    && con_q[1:0] == 2'h3 && con_q == $past(con_q, 2) |-> sclk_o == con_q[3])
    else $error("clock idle level wrong");
  sclk_step_a: assert property ($changed(sclk_o) && !cs_n_o && !$past(cs_n_o)
    && !$past(cs_n_o, 2) |-> (run_q + 9'h001) % half_w == 9'h000)
    else $error("clock half period wrong");
  frame_length_a: assert property ($rose(cs_n_o) && con_q[1:0] == 2'h3 && !con_q[12]
    |-> low_q == {half_w, 4'h0})
    else $error("byte frame length wrong");
  stall_gap_a: assert property ($fell(cs_n_o) |-> hi_q >= STALL_HALVES * half_w)
    else $error("stall between bytes too short");
endmodule

// ---- verification/spc_slave_model.sv ----
`timescale 1ns/1ps
module spc_slave_model (
  // serial pins
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  // first byte of each frame
  input  wire logic [7:0] rsp,
  // data line out
  output logic            miso,
  output logic            miso_oe,
  // last byte taken, count
  output logic [7:0]      got,
  output int              n_got
);
  logic [7:0] tx_q  = 8'h00;  // outgoing shifter
  logic [7:0] rx_q  = 8'h00;  // incoming shifter
  logic [2:0] cnt_q = 3'h0;   // bits of this byte
  initial n_got = 0;
  // select low opens a frame
  always @(negedge cs_n) begin
    tx_q  = rsp;
    cnt_q = 3'h0;
  end
  // sample on rising clock, msb first, eight bits a byte
  always @(posedge sclk) begin
    if (!cs_n) begin
      rx_q  = {rx_q[6:0], mosi};
      cnt_q = cnt_q + 3'h1;
      if (cnt_q == 3'h0) begin
        got = rx_q;
        n_got++;
      end
    end
  end
  // shift on falling clock; later bytes of a frame send the inverse
  always @(negedge sclk) begin
    if (!cs_n) begin
      tx_q = (cnt_q == 3'h0) ? ~rsp : {tx_q[6:0], 1'b0};
    end
  end
  // a released line shows the inverse of the last bit
  assign miso_oe = !cs_n;
  assign miso    = cs_n ? ~tx_q[7] : tx_q[7];
endmodule

// ---- verification/spc_port_control_tb.sv ----
`timescale 1ns/1ps
`include "spc_params.svh"
module spc_port_control_tb;
  // ****
  // bus, pins and bookkeeping
  // ****
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, seed;
  logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, cs_n_o, cs_n_oe;
  logic        p_miso, p_oe;
  logic [7:0]  p_got, rsp, b, b2;
  logic [32:0] e, exp_rd[$];  // bit 32 set: compare
  logic [7:0]  exp_sb[$];     // bytes the far side should see
  int          p_n, p_seen, n_mismatch, samples_checked, cs_rises, c0;
  // wire levels, clock pulled low and the rest pulled up where nobody drives
  wire sclk_w = sclk_oe ? sclk_o : 1'b0;
  wire mosi_w = mosi_oe ? mosi_o : 1'b1;
  wire cs_w   = cs_n_oe ? cs_n_o : 1'b1;
  wire miso_w = miso_oe ? miso_o : (p_oe ? p_miso : 1'b1);
  spc_port u_spc_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe(miso_oe), .cs_n_i(cs_w), .cs_n_o(cs_n_o), .cs_n_oe(cs_n_oe));
  spc_slave_model u_spc_slave_model (.sclk(sclk_w), .mosi(mosi_w), .cs_n(cs_w),
    .rsp(rsp), .miso(p_miso), .miso_oe(p_oe), .got(p_got), .n_got(p_n));
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  always @(posedge cs_w) cs_rises++;
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one apb transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (!pready && n < 20);
    if (!pready) begin check("ready", 0, 1); report_and_stop; end
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, x, input logic c);
    exp_rd.push_back({c, x});
    apb(1'b0, a, 32'h0);
  endtask
  // wait until the far side has all bytes and select is high
  task automatic drain;
    int n;
    for (n = 0; n < 3000 && (exp_sb.size() != 0 || !cs_w); n++) @(posedge pclk);
    if (n >= 3000) begin check("drain", 0, 1); report_and_stop; end
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction
  // watcher: compares each result with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) check("slave error", pslverr, paddr == 32'hffff0a20);
    if (psel && penable && pready && !pwrite) begin
      e = exp_rd.pop_front();
      if (e[32]) check("read data", prdata, e[31:0]);
    end
    if (p_n != p_seen) begin
      p_seen = p_n;
      check("far byte", p_got, exp_sb.size() ? exp_sb.pop_front() : 8'hxx);
    end
  end
  initial begin
    seed = 32'he408a3c4; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; rsp = 8'hc6; p_seen = 0; cs_rises = 0;
    n_mismatch = 0; samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SPC_ADDR_DIV, 32'h1b, 1);
    rd(`SPC_ADDR_CON, 32'h0, 1);
    rd(`SPC_ADDR_TX, 32'h0, 1);
    rd(32'hffff0a20, 32'h0, 1);
    apb(1, `SPC_ADDR_CON, 32'hffffffff);
    rd(`SPC_ADDR_CON, 32'h1fef, 1);
    b = 8'($random(seed));
    apb(1, `SPC_ADDR_DIV, {24'h0, b});
    rd(`SPC_ADDR_DIV, {24'h0, b}, 1);
    apb(1, `SPC_ADDR_DIV, 32'h1);
    // single bytes started by writes, both bit orders
    for (int l = 0; l < 2; l++) begin
      rsp = 8'($random(seed));
      b = 8'($random(seed));
      apb(1, `SPC_ADDR_CON, 32'h43 | (l << 5));
      exp_sb.push_back(l ? rev8(b) : b);
      apb(1, `SPC_ADDR_TX, {24'h0, b});
      drain;
      rd(`SPC_ADDR_RX, {24'h0, l ? rev8(rsp) : rsp}, 1);
    end
    // loopback returns our own byte
    apb(1, `SPC_ADDR_CON, 32'h843);
    exp_sb.push_back(b);
    apb(1, `SPC_ADDR_TX, {24'h0, b});
    drain;
    rd(`SPC_ADDR_RX, {24'h0, b}, 1);
    // read-started transfers with nothing to send: resend, then zero
    apb(1, `SPC_ADDR_CON, 32'h03);
    exp_sb.push_back(b);
    rd(`SPC_ADDR_RX, {24'h0, b}, 1);
    drain;
    apb(1, `SPC_ADDR_CON, 32'h83);
    exp_sb.push_back(8'h00);
    rd(`SPC_ADDR_RX, {24'h0, rsp}, 1);
    drain;
    // continuous pair, overflow discard then overwrite
    for (int o = 0; o < 2; o++) begin
      apb(1, `SPC_ADDR_CON, 32'h1043 | (o << 8));
      c0 = cs_rises;
      b = 8'($random(seed));
      b2 = 8'($random(seed));
      exp_sb.push_back(b);
      exp_sb.push_back(b2);
      apb(1, `SPC_ADDR_TX, {24'h0, b});
      apb(1, `SPC_ADDR_TX, {24'h0, b2});
      drain;
      check("select releases", cs_rises - c0, 1);
      rd(`SPC_ADDR_STA, 32'h3a, 1);
      rd(`SPC_ADDR_RX, {24'h0, o ? ~rsp : rsp}, 1);
    end
    // idle high clock, select output off, then slave open drain
    apb(1, `SPC_ADDR_CON, 32'h24f);
    apb(1, `SPC_ADDR_TX, {24'h0, b});
    apb(1, `SPC_ADDR_CON, 32'h401);
    rd(`SPC_ADDR_CON, 32'h401, 1);
    report_and_stop;
  end
endmodule
bind spc_port spc_port_monitor #(.STALL_HALVES(STALL_HALVES)) u_spc_port_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .sclk_o(sclk_o),
  .sclk_oe(sclk_oe), .miso_o(miso_o), .miso_oe(miso_oe), .cs_n_o(cs_n_o), .cs_n_oe(cs_n_oe));
